//--- logic/page_mapper_pkg.sv
// shared constants for the virtual page mapper
package page_mapper_pkg;
    // address widths
    localparam int VADDR_W      = 16;
    localparam int OFFSET_W     = 10;
    localparam int VPN_W        = VADDR_W - OFFSET_W;
    localparam int PADDR_NORM_W = 19;
    localparam int PADDR_EXT_W  = 24;
    localparam int PPN_EXT_W    = PADDR_EXT_W - OFFSET_W;
    localparam int PPN_NORM_W   = PADDR_NORM_W - OFFSET_W;
    localparam int TABLES       = 4;
    localparam int RINGS        = 4;
    localparam int PAGES        = 1 << VPN_W;

    // register byte offsets
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_MASK   = 12'h008;
    localparam logic [11:0] OFF_FAULT  = 12'h00C;
    localparam logic [11:0] OFF_TABLE  = 12'h400;

    // control fields
    localparam int CTRL_EXT_BIT  = 0;
    localparam int CTRL_TSEL_LSB = 4;
    localparam int CTRL_RING_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // status and mask fields
    localparam int ST_PERM_BIT = 0;
    localparam int ST_RING_BIT = 1;
    localparam int ST_W        = 2;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET   = 2'h0;

    // page table entry fields
    localparam int PTE_PPN_LSB  = 0;
    localparam int PTE_RD_BIT   = 16;
    localparam int PTE_WR_BIT   = 17;
    localparam int PTE_FX_BIT   = 18;
    localparam int PTE_RING_LSB = 20;
    localparam int PTE_W        = 22;

    // fault capture fields
    localparam int FLT_ACC_LSB  = 16;
    localparam int FLT_TSEL_LSB = 20;

    // processor access kinds
    typedef enum logic [1:0] {
        ACC_READ  = 2'b00,
        ACC_WRITE = 2'b01,
        ACC_FETCH = 2'b10
    } access_t;
endpackage

//--- logic/virtual_page_mapper.sv
// virtual page mapper: translation, page and ring protection, apb registers
//
// How it works
// - normal mode gives 19-bit physical word address
// - extended mode gives 24-bit physical word address
// - pages are 1K words each
// - four register page tables hold page numbers
// - per-page read, write, fetch permits block accesses
// - pages and running program carry ring numbers
// - refuse access when program ring below page ring
// - each program sees full 64K word space
`timescale 1ns/1ns

module virtual_page_mapper #(
    parameter int TABLE_COUNT = page_mapper_pkg::TABLES,
    parameter int RING_COUNT  = page_mapper_pkg::RINGS
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // processor side
    input  wire logic        i_req,
    input  wire logic [15:0] i_vaddr,
    input  wire logic [1:0]  i_access,
    // bus side
    output logic             o_valid,
    output logic [23:0]      o_paddr,
    output logic [1:0]       o_access,
    output logic             o_fault,
    output logic             o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks: table and ring fields are two bits wide
    if (TABLE_COUNT != page_mapper_pkg::TABLES || RING_COUNT != page_mapper_pkg::RINGS) begin : g_bad_cfg
        $error("mapper supports exactly four tables and four rings");
    end
    // entry must fit one bus word, normal page number inside extended one
    if (page_mapper_pkg::PTE_W > 32) begin : g_bad_pte
        $error("page table entry wider than a bus word");
    end
    if (page_mapper_pkg::PPN_NORM_W > page_mapper_pkg::PPN_EXT_W) begin : g_bad_ppn
        $error("normal page number wider than extended one");
    end

    ////////////////////////////////////////////////////////////////////////
    // operating notes
    //
    // register map, byte addresses on the apb side
    //   0x000 control: bit 0 extended mode, bits 5:4 table, bits 9:8 ring
    //   0x004 status: bit 0 permission fault, bit 1 ring fault
    //   0x008 mask: same layout as status, a one enables the interrupt
    //   0x00c capture: vaddr, access kind and table of the first fault
    //   0x400..0x7fc page table window, four tables of 64 words
    //
    // page table word
    //   bits 13:0 physical page number, low nine used in normal mode
    //   bit 16 read allowed, bit 17 write allowed, bit 18 fetch allowed
    //   bits 21:20 ring of the page, higher number more privileged
    //   bits 31:22 read back as zero and are not stored; bits 15:14 and 19 are stored and read back
    //
    // translation timing
    //   request taken at every rising edge with i_req high
    //   answer one cycle later: o_valid or o_fault, never both
    //   back to back requests allowed, one per cycle
    //   o_access mirrors the kind for refused requests too
    //   a refused request shows address zero, so nothing leaks
    //
    // register access timing
    //   one wait state: pready the cycle after the first access edge
    //   writes land on that first access edge, not at pready
    //   unmapped or unaligned words answer with pslverr, no write
    //   reads of unmapped words return zero
    //
    // cycle walk of one translation
    //   c0: i_req, i_vaddr, i_access on the pins
    //   edge: entry read, permits and ring compared, result registered
    //   c1: o_valid or o_fault, o_paddr, o_access stand one cycle
    //   same edge: status bit set; o_irq follows with the mask
    //
    // cycle walk of one register access
    //   c0: psel high with address, direction and data
    //   c1: penable high; the edge closing c1 takes the access
    //   c2: pready with prdata and pslverr for one cycle
    //   c3: bus released or next setup
    //
    // bus side view
    //   o_paddr is a word address: 24 bits extended, 19 bits normal
    //   in normal mode bits 23:19 stay zero
    //   1K word pages: the low ten bits pass through untouched
    //   each program sees 64K words whatever memory is fitted
    //
    // interrupt
    //   o_irq is a level, high while an unmasked status bit is set
    //   cleared by writing ones to the status bits that are set
    //   it rises on the same edge that sets the status bit
    //
    // reset
    //   i_reset_n acts at once; release passes two flops first
    //   first access is safe on the third edge after release
    //
    // hazards and limits
    //   table words are not reset: software fills every entry it uses
    //   table writes while requests run take effect next cycle
    //   control changes act on the very next request, no fence
    //   status set beats a same-cycle clear, so no event is lost
    //   capture only refills once status reads all zero again
    //   kind 11 is refused as a permission fault
    //   table and ring counts are fixed at four: two-bit fields
    //
    // bring-up sequence for software
    //   fill the table entries of every page a program may touch
    //   write control with table, ring and mode
    //   set the mask bits for the faults that should interrupt
    //   start the program; on interrupt read capture, then status
    //   clear status last, which rearms the capture word
    //
    // debugging hints
    //   a stuck fault often means a stale entry in the wrong table
    //   capture shows the table that was selected at the fault
    //   ring faults and permission faults may set both bits at once
    //
    // trade-offs
    //   lookup is a plain array read, so the answer can be registered
    //   in one cycle without a second pipeline stage
    //   the array stays unreset to keep it in cheap storage

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    logic [31:0] ctrl_reg;
    logic [1:0]  status_reg;
    logic [1:0]  status_next;
    logic [1:0]  mask_reg;
    logic [31:0] fault_reg;
    logic [31:0] fault_next;
    logic [31:0] prdata_next;
    logic        pslverr_next;

    wire         apb_access = psel && penable && !pready;
    wire         apb_wr     = apb_access && pwrite;
    wire         hit_ctrl   = paddr == page_mapper_pkg::OFF_CTRL;
    wire         hit_status = paddr == page_mapper_pkg::OFF_STATUS;
    wire         hit_mask   = paddr == page_mapper_pkg::OFF_MASK;
    wire         hit_fault  = paddr == page_mapper_pkg::OFF_FAULT;
    // table window: 4 tables of 64 entries, one word each
    wire         hit_table  = paddr[11:10] == page_mapper_pkg::OFF_TABLE[11:10];
    wire [7:0]   tbl_index  = paddr[9:2];
    wire         aligned    = paddr[1:0] == 2'b00;
    wire         mapped     = aligned && (hit_ctrl || hit_status || hit_mask || hit_fault || hit_table);

    ////////////////////////////////////////////////////////////////////////
    // write strobes for control, status, mask and table (capture has none); only aligned mapped words write
    wire         wr_ctrl    = apb_wr && aligned && hit_ctrl;
    wire         wr_status  = apb_wr && aligned && hit_status;
    wire         wr_mask    = apb_wr && aligned && hit_mask;
    wire         wr_table   = apb_wr && aligned && hit_table;

    ////////////////////////////////////////////////////////////////////////
    // page tables in fast register storage, indexed {table, page}
    logic [page_mapper_pkg::PTE_W-1:0] table_mem [0:page_mapper_pkg::TABLES*page_mapper_pkg::PAGES-1];

    // tables are software state; no reset on purpose, keeps the array cheap
    always_ff @(posedge i_clk) begin
        if (wr_table) begin
            table_mem[tbl_index] <= pwdata[page_mapper_pkg::PTE_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control fields steering translation
    wire       mode_ext  = ctrl_reg[page_mapper_pkg::CTRL_EXT_BIT];
    wire [1:0] table_sel = ctrl_reg[page_mapper_pkg::CTRL_TSEL_LSB +: 2];
    wire [1:0] prog_ring = ctrl_reg[page_mapper_pkg::CTRL_RING_LSB +: 2];

    // lookup: all 16 address bits used, full 64K word space per program
    wire [page_mapper_pkg::VPN_W-1:0]    vpage  = i_vaddr[15:page_mapper_pkg::OFFSET_W];
    wire [page_mapper_pkg::OFFSET_W-1:0] offset = i_vaddr[page_mapper_pkg::OFFSET_W-1:0];
    wire [page_mapper_pkg::PTE_W-1:0]    pte    = table_mem[{table_sel, vpage}];

    wire [page_mapper_pkg::PPN_EXT_W-1:0] ppn_ext  = pte[page_mapper_pkg::PTE_PPN_LSB +: page_mapper_pkg::PPN_EXT_W];
    wire [page_mapper_pkg::PPN_EXT_W-1:0] ppn_norm = {
        {(page_mapper_pkg::PPN_EXT_W-page_mapper_pkg::PPN_NORM_W){1'b0}},
        ppn_ext[page_mapper_pkg::PPN_NORM_W-1:0]
    };
    wire [page_mapper_pkg::PPN_EXT_W-1:0] ppn_sel  = mode_ext ? ppn_ext : ppn_norm;
    wire [23:0] paddr_next = {ppn_sel, offset};

    // permission for the requested kind of access
    function automatic logic permit(input logic [1:0] acc, input logic [page_mapper_pkg::PTE_W-1:0] e);
        logic ok;
        ok = 1'b0;
        case (acc)
            page_mapper_pkg::ACC_READ:  ok = e[page_mapper_pkg::PTE_RD_BIT];
            page_mapper_pkg::ACC_WRITE: ok = e[page_mapper_pkg::PTE_WR_BIT];
            page_mapper_pkg::ACC_FETCH: ok = e[page_mapper_pkg::PTE_FX_BIT];
            default:                    ok = 1'b0; // unknown kind refused
        endcase
        return ok;
    endfunction

    wire [1:0] page_ring  = pte[page_mapper_pkg::PTE_RING_LSB +: 2];
    wire       perm_fail  = i_req && !permit(i_access, pte);
    wire       ring_fail  = i_req && (prog_ring < page_ring);
    wire       any_fail   = perm_fail || ring_fail;
    wire [1:0] ev_set     = {ring_fail, perm_fail};

    ////////////////////////////////////////////////////////////////////////
    // translation output stage, one cycle after the request
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_valid  <= 1'b0;
            o_fault  <= 1'b0;
            o_paddr  <= 24'h00_0000;
            o_access <= 2'h0;
        end else begin
            o_valid  <= i_req && !any_fail;
            o_fault  <= any_fail;
            o_paddr  <= any_fail ? 24'h00_0000 : paddr_next; // blocked access never reaches the bus
            o_access <= i_access;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status: new event beats a same-cycle clear
    wire [1:0] st_clear = wr_status ? pwdata[page_mapper_pkg::ST_W-1:0] : 2'h0;
    assign status_next  = (status_reg & ~st_clear) | ev_set;

    // fault capture holds the first fault until status fully cleared
    assign fault_next = (any_fail && status_reg == 2'h0)
                      ? {10'h000, table_sel, 2'h0, i_access, i_vaddr}
                      : fault_reg;

    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ctrl_reg   <= page_mapper_pkg::CTRL_RESET;
            status_reg <= page_mapper_pkg::STATUS_RESET;
            mask_reg   <= page_mapper_pkg::MASK_RESET;
            fault_reg  <= 32'h0000_0000;
            o_irq      <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= pwdata & 32'h0000_0331; // only mode, table and ring bits kept
            end
            if (wr_mask) begin
                mask_reg <= pwdata[page_mapper_pkg::ST_W-1:0];
            end
            status_reg <= status_next;
            fault_reg  <= fault_next;
            o_irq      <= |(status_next & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb read mux and answer; one wait state keeps all outputs registered
    wire [31:0] pte_word = {{(32-page_mapper_pkg::PTE_W){1'b0}}, table_mem[tbl_index]};

    always_comb begin
        prdata_next  = 32'h0000_0000;
        pslverr_next = !mapped;
        if (mapped && !pwrite) begin
            if (hit_ctrl) begin
                prdata_next = ctrl_reg;
            end else if (hit_status) begin
                prdata_next = {30'h0000_0000, status_reg};
            end else if (hit_mask) begin
                prdata_next = {30'h0000_0000, mask_reg};
            end else if (hit_fault) begin
                prdata_next = fault_reg;
            end else begin
                prdata_next = pte_word;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_access;
            pslverr <= apb_access && pslverr_next;
            prdata  <= apb_access ? prdata_next : 32'h0000_0000;
        end
    end

endmodule

//--- verif/cpu_model.sv
// processor model issuing translation requests
`timescale 1ns/1ns
module cpu_model (
    input  wire logic        i_clk,
    output logic             o_req,
    output logic [15:0]      o_vaddr,
    output logic [1:0]       o_access
);
    initial begin
        o_req = 1'b0;
        o_vaddr = 16'h0000;
        o_access = 2'h0;
    end
    // one request cycle; lines scrambled once released so stale values never match
    task automatic issue(input logic [15:0] va, input logic [1:0] acc);
        o_req    <= 1'b1;
        o_vaddr  <= va;
        o_access <= acc;
        @(posedge i_clk);
        o_req    <= 1'b0;
        o_vaddr  <= ~va;
        o_access <= ~acc;
    endtask
endmodule

//--- verif/testbench.sv
// self-checking bench for the virtual page mapper
`timescale 1ns/1ns
module testbench;
    typedef struct packed {logic [15:0] va; logic [1:0] acc; logic ok; logic [23:0] pa;} row_t;
    logic i_clk = 1'b0, i_reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, i_req, o_valid, o_fault, o_irq, err;
    logic [15:0] i_vaddr;
    logic [1:0]  i_access, o_access;
    logic [23:0] o_paddr;
    int miscompares = 0, cmp_count = 0, cyc = 0;
    // extended mode, table 1, program ring 2
    row_t rows [6] = '{'{16'h03ff, 2'h0, 1'b1, 24'haa_f3ff}, '{16'h03ff, 2'h1, 1'b1, 24'haa_f3ff},
        '{16'h03ff, 2'h2, 1'b0, 24'h00_0000}, '{16'h1400, 2'h2, 1'b0, 24'h00_0000},
        '{16'h1955, 2'h0, 1'b1, 24'hff_fd55}, '{16'h1955, 2'h3, 1'b0, 24'h00_0000}};
    virtual_page_mapper dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_req(i_req), .i_vaddr(i_vaddr), .i_access(i_access), .o_valid(o_valid),
        .o_paddr(o_paddr), .o_access(o_access), .o_fault(o_fault), .o_irq(o_irq));
    cpu_model cpu_u (.i_clk(i_clk), .o_req(i_req), .o_vaddr(i_vaddr), .o_access(i_access));
    always #20 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic xlat(input row_t r);
        cpu_u.issue(r.va, r.acc);
        #1;
        chk("valid", o_valid, r.ok);
        chk("fault", o_fault, !r.ok);
        chk("paddr", o_paddr, r.pa);
        chk("access", o_access, r.acc);
        @(posedge i_clk);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard, run needs about a hundred cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            summarize;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0000_0000);
            chk("reset_value", rd, 32'h0000_0000);
        end
        apb(1'b1, 12'h000, 32'h0000_0211);
        apb(1'b1, 12'h500, 32'h0013_2abc);
        apb(1'b1, 12'h514, 32'h0034_0123);
        apb(1'b1, 12'h518, 32'h0027_3fff);
        apb(1'b0, 12'h518, 32'h0000_0000);
        chk("entry", rd, 32'h0027_3fff);
        $display("test registers done");
        foreach (rows[i]) xlat(rows[i]);
        $display("test rows done");
        // normal mode keeps only nine page number bits
        apb(1'b1, 12'h000, 32'h0000_0210);
        xlat('{16'h1955, 2'h0, 1'b1, 24'h07_fd55});
        chk("irq_masked", o_irq, 1'b0);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk("status", rd, 32'h0000_0003);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk("capture", rd, 32'h0012_03ff);
        apb(1'b1, 12'h008, 32'h0000_0001);
        #1 chk("irq", o_irq, 1'b1);
        @(posedge i_clk);
        apb(1'b1, 12'h004, 32'h0000_0001);
        #1 chk("irq_clear", o_irq, 1'b0);
        @(posedge i_clk);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk("status_clear", rd, 32'h0000_0002);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk("unmapped", err, 1'b1);
        $display("test interrupt done");
        // mid-run reset clears control, status and outputs
        i_reset_n <= 1'b0;
        @(posedge i_clk);
        #1 chk("reset_paddr", o_paddr, 24'h00_0000);
        chk("reset_valid", o_valid, 1'b0);
        repeat (5) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("reset_ctrl", rd, 32'h0000_0000);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk("reset_status", rd, 32'h0000_0000);
        $display("test reset done");
        summarize;
    end
endmodule

//--- verif/vpm_properties.sv
// port-level checker for the virtual page mapper
`timescale 1ns/1ns
module vpm_props (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        i_req,
    input wire logic [15:0] i_vaddr,
    input wire logic [1:0]  i_access,
    input wire logic        o_valid,
    input wire logic [23:0] o_paddr,
    input wire logic [1:0]  o_access,
    input wire logic        o_fault
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // every request gets exactly one answer a cycle later
    property p_answer; i_req |=> o_valid ^ o_fault; endproperty
    a_answer: assert property (p_answer) else $error("request without single answer");
    property p_idle; !i_req |=> !o_valid && !o_fault; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_offset; i_req ##1 o_valid |-> o_paddr[9:0] == $past(i_vaddr[9:0]); endproperty
    a_offset: assert property (p_offset) else $error("page offset altered");
    property p_kind; i_req |=> o_access == $past(i_access); endproperty
    a_kind: assert property (p_kind) else $error("access kind not carried");
    property p_bad; i_req && i_access == 2'h3 |=> o_fault; endproperty
    a_bad: assert property (p_bad) else $error("unknown kind let through");
    property p_zero; o_fault |-> o_paddr == 24'h00_0000; endproperty
    a_zero: assert property (p_zero) else $error("refused access leaks address");
    property p_ready; psel && penable && !pready |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("register access not answered");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
endmodule
bind virtual_page_mapper vpm_props chk_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .psel(psel),
    .penable(penable), .pready(pready), .i_req(i_req), .i_vaddr(i_vaddr), .i_access(i_access),
    .o_valid(o_valid), .o_paddr(o_paddr), .o_access(o_access), .o_fault(o_fault));
